// ===== hdl/spi_port_pkg.sv
// Shared constants for the serial host port: register map, reset values,
// field positions, counts and the serial state encoding.
// Assumes a single 40 MHz system clock domain.
package spi_port_pkg;
    // Register offsets (six-bit address space)
    localparam logic [5:0] ADDR_CONFIG = 6'h05;
    localparam logic [5:0] ADDR_RX_EN = 6'h07;
    localparam logic [5:0] ADDR_RX_STAT = 6'h08;
    localparam logic [5:0] ADDR_TX_EN = 6'h0d;
    localparam logic [5:0] ADDR_TX_STAT = 6'h0e;
    localparam logic [5:0] ADDR_WAKE_EN = 6'h1c;
    localparam logic [5:0] ADDR_WAKE_STAT = 6'h1d;

    // Values after reset
    localparam logic [7:0] RST_CONFIG = 8'h01;
    localparam logic [7:0] RST_RX_EN = 8'h00;
    localparam logic [7:0] RST_TX_EN = 8'h00;
    localparam logic [7:0] RST_WAKE_EN = 8'h00;
    localparam logic [7:0] RST_RX_STAT = 8'h00;
    localparam logic [3:0] RST_TX_STAT = 4'h0;
    localparam logic RST_WAKE_STAT = 1'b1;

    // Field positions
    localparam int CMD_DIR_BIT = 7;
    localparam int CMD_INC_BIT = 6;
    localparam int CFG_POL_BIT = 0;
    localparam int WAKE_BIT = 0;
    localparam int SER_B_LO = 4;

    // Cycle counts
    localparam int OSC_START_CYC = 64;
    localparam int BIT_CLK_HALF_CYC = 20;

    // Bypass FIFO shape
    localparam int FIFO_WIDTH = 2;
    localparam int FIFO_DEPTH = 32;

    // Serial engine states, Gray along idle -> command -> data
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD = 2'b01,
        ST_DATA = 2'b11
    } spi_state_t;
endpackage

// ===== hdl/sync_2ff.sv
// Two-flop level synchroniser for a bundle of independent pins.
// Assumes each bit is a slow level or an edge that lasts several clocks.
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // sync_2ff

// ===== hdl/bit_fifo.sv
// Synchronous FIFO with valid/ready on both sides and registered flags.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
module bit_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rptr];
    assign next_count = count + CW'(push) - CW'(pop);

    // Storage; no reset needed on the data itself
    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wptr] <= in_data;
    end

    // Pointers and flags registered so ready never loops back combinationally
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
                wptr <= wptr + AW'(1);
            if (pop)
                rptr <= rptr + AW'(1);
            count <= next_count;
            in_ready <= (next_count != CW'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end
endmodule // bit_fifo

// ===== hdl/spi_irq_port.sv
// Host port of the radio: serial slave with register file, shared
// interrupt pin and the serializer-bypass bit path clocked by that pin.
// Assumes all pins are asynchronous to sys_clk and that the serial clock
// runs no faster than one eighth of sys_clk.
`timescale 1ns/1ps
module spi_irq_port (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Serial pins
    input wire logic spi_sck,
    input wire logic spi_mosi,
    input wire logic spi_ss_n,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Interrupt / bypass bit clock pin
    input wire logic irq_in,
    output logic irq_out,
    output logic irq_oe,
    // Power control pin
    input wire logic power_down_n,
    // Bypass data pins
    input wire logic bypass_bit_data_in,
    output logic bypass_bit_data_out,
    output logic bypass_bit_data_oe,
    input wire logic bypass_bit_valid_in,
    output logic bypass_bit_valid_out,
    output logic bypass_bit_valid_oe,
    // Baseband status and events
    input wire logic tx_mode_active,
    input wire logic rx_mode_active,
    input wire logic single_serializer_mode,
    input wire logic bypass_enable,
    input wire logic [3:0] tx_event,
    input wire logic [7:0] rx_event,
    // Bypass receive bits from the baseband
    input wire logic core_bit_push,
    input wire logic core_bit_data,
    input wire logic core_bit_valid,
    output logic core_bit_ready,
    // Bypass transmit bits to the baseband
    output logic tx_bit_strobe,
    output logic tx_bit_data,
    output logic tx_bit_valid,
    // Oscillator state
    output logic osc_running
);
    import spi_port_pkg::*;

    localparam int OSC_CW = $clog2(OSC_START_CYC + 1);
    localparam int DIV_CW = $clog2(BIT_CLK_HALF_CYC);

    logic [5:0] pins_raw;
    logic [5:0] pins_s;
    logic sck_s, mosi_s, ss_s, pd_s, dio_s, bypass_bit_valid_s;
    logic sck_d;
    logic sck_rise;
    spi_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] byte_in;
    logic byte_done;
    logic is_write;
    logic is_inc;
    logic [5:0] addr;
    logic [5:0] next_addr;
    logic [5:0] rd_addr;
    logic rd_stb;
    logic wr_stb;
    logic [7:0] rd_data;
    logic [7:0] cfg;
    logic [7:0] rx_en;
    logic [7:0] tx_en;
    logic [7:0] wake_en;
    logic [7:0] rx_stat;
    logic [3:0] tx_stat;
    logic wake_stat;
    logic wake_set;
    logic [7:0] rx_set;
    logic [OSC_CW-1:0] osc_cnt;
    logic tx_hit, rx_hit, wake_hit, irq_pend;
    logic [DIV_CW-1:0] div_cnt;
    logic bit_clk;
    logic bit_fall;
    logic fifo_valid;
    logic [1:0] fifo_data;
    logic fifo_pop;

    // Every pin crosses two flops before use
    assign pins_raw = {bypass_bit_valid_in, bypass_bit_data_in, power_down_n,
        spi_ss_n, spi_mosi, spi_sck};
    sync_2ff #(
        .WIDTH(6)
    ) pin_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .d(pins_raw),
        .q(pins_s)
    );
    assign {bypass_bit_valid_s, dio_s, pd_s, ss_s, mosi_s, sck_s} = pins_s;

    // Rising serial clock edge, only while selected and oscillator runs
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            sck_d <= 1'b0;
        else
            sck_d <= sck_s;
    end
    assign sck_rise = sck_s && !sck_d && !ss_s && osc_running;
    assign byte_in = {rx_shift[6:0], mosi_s};
    assign byte_done = sck_rise && (bit_cnt == 3'd7);

    // Command fields and address step
    assign next_addr = is_inc ? addr + 6'h01 : addr;
    assign wr_stb = byte_done && (state == ST_DATA) && is_write;
    assign rd_stb = byte_done && !(state == ST_DATA && is_write)
        && !(state == ST_CMD && byte_in[CMD_DIR_BIT]);
    assign rd_addr = (state == ST_CMD) ? byte_in[5:0] : next_addr;

    // Register read mux; unmapped addresses read zero
    always_comb
    begin
        case (rd_addr)
            ADDR_CONFIG: rd_data = cfg;
            ADDR_RX_EN: rd_data = rx_en;
            ADDR_RX_STAT: rd_data = rx_stat;
            ADDR_TX_EN: rd_data = tx_en;
            ADDR_TX_STAT: rd_data = {4'h0, tx_stat};
            ADDR_WAKE_EN: rd_data = wake_en;
            ADDR_WAKE_STAT: rd_data = {7'h00, wake_stat};
            default: rd_data = 8'h00;
        endcase
    end

    // Transaction sequencer: select high always returns to idle
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            bit_cnt <= 3'd0;
            rx_shift <= 8'h00;
            addr <= 6'h00;
            is_write <= 1'b0;
            is_inc <= 1'b0;
        end
        else if (ss_s || !osc_running)
        begin
            state <= ST_IDLE;
            bit_cnt <= 3'd0;
        end
        else
        begin
            if (state == ST_IDLE)
                state <= ST_CMD;
            if (sck_rise)
            begin
                bit_cnt <= bit_cnt + 3'd1;
                rx_shift <= byte_in;
            end
            if (byte_done && state == ST_CMD)
            begin
                state <= ST_DATA;
                is_write <= byte_in[CMD_DIR_BIT];
                is_inc <= byte_in[CMD_INC_BIT];
                addr <= byte_in[5:0];
            end
            else if (byte_done && state == ST_DATA)
                addr <= next_addr;
        end
    end

    // Answer shift: new bit shortly after each sampling edge, so it is
    // stable well before the next one even with pin sync latency
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_shift <= 8'h00;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end
        else
        begin
            spi_miso_oe <= !ss_s && osc_running;
            if (ss_s)
                spi_miso <= 1'b0;
            else if (rd_stb)
            begin
                spi_miso <= rd_data[7];
                tx_shift <= {rd_data[6:0], 1'b0};
            end
            else if (byte_done)
                spi_miso <= 1'b0;
            else if (sck_rise)
            begin
                spi_miso <= tx_shift[7];
                tx_shift <= {tx_shift[6:0], 1'b0};
            end
        end
    end

    // Writable registers change only by serial writes, never by mode
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg <= RST_CONFIG;
            rx_en <= RST_RX_EN;
            tx_en <= RST_TX_EN;
            wake_en <= RST_WAKE_EN;
        end
        else if (wr_stb)
        begin
            case (addr)
                ADDR_CONFIG: cfg <= byte_in;
                ADDR_RX_EN: rx_en <= byte_in;
                ADDR_TX_EN: tx_en <= byte_in;
                ADDR_WAKE_EN: wake_en <= byte_in;
                default: ;
            endcase
        end
    end

    // Oscillator start-up model: held stopped while power-down is low
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            osc_cnt <= '0;
            osc_running <= 1'b0;
        end
        else if (!pd_s)
        begin
            osc_cnt <= '0;
            osc_running <= 1'b0;
        end
        else if (osc_cnt != OSC_CW'(OSC_START_CYC))
            osc_cnt <= osc_cnt + OSC_CW'(1);
        else
            osc_running <= 1'b1;
    end
    assign wake_set = pd_s && !osc_running && (osc_cnt == OSC_CW'(OSC_START_CYC));

    // Sticky status, set regardless of enable; a set beats a read clear.
    // Reads that prefetch past the end of a burst clear as well.
    assign rx_set = single_serializer_mode ? {4'h0, rx_event[SER_B_LO-1:0]} : rx_event;
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_stat <= RST_RX_STAT;
            tx_stat <= RST_TX_STAT;
            wake_stat <= RST_WAKE_STAT;
        end
        else
        begin
            if (rd_stb && rd_addr == ADDR_RX_STAT)
                rx_stat <= rx_set;
            else
                rx_stat <= rx_stat | rx_set;
            if (rd_stb && rd_addr == ADDR_TX_STAT)
                tx_stat <= tx_event;
            else
                tx_stat <= tx_stat | tx_event;
            if (wake_set)
                wake_stat <= 1'b1;
            else if (rd_stb && rd_addr == ADDR_WAKE_STAT)
                wake_stat <= 1'b0;
        end
    end

    // Shared interrupt; each mode hides the other's sources
    assign wake_hit = wake_stat && wake_en[WAKE_BIT];
    assign tx_hit = |(tx_stat & tx_en[3:0]) && !rx_mode_active;
    assign rx_hit = |(rx_stat & rx_en) && !tx_mode_active;
    assign irq_pend = wake_hit || tx_hit || rx_hit;

    // Bypass bit clock divider, a free toggle while bypass is enabled
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_cnt <= '0;
            bit_clk <= 1'b1;
        end
        else if (!bypass_enable)
        begin
            div_cnt <= '0;
            bit_clk <= 1'b1;
        end
        else if (div_cnt == DIV_CW'(BIT_CLK_HALF_CYC - 1))
        begin
            div_cnt <= '0;
            bit_clk <= !bit_clk;
        end
        else
            div_cnt <= div_cnt + DIV_CW'(1);
    end
    assign bit_fall = bypass_enable && bit_clk
        && (div_cnt == DIV_CW'(BIT_CLK_HALF_CYC - 1));

    // Pin driver: bit clock in bypass, else only the active level is driven
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_out <= 1'b0;
            irq_oe <= 1'b0;
        end
        else if (bypass_enable)
        begin
            irq_out <= bit_clk ^ bit_fall;
            irq_oe <= 1'b1;
        end
        else
        begin
            irq_out <= cfg[CFG_POL_BIT];
            irq_oe <= irq_pend;
        end
    end

    // Receive bits buffered so the baseband can run ahead of the pin clock
    assign fifo_pop = bit_fall && rx_mode_active;
    bit_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) rx_bits (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(core_bit_push),
        .in_ready(core_bit_ready),
        .in_data({core_bit_valid, core_bit_data}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // Bypass pins: present on receive falls, sample on transmit falls
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bypass_bit_data_out <= 1'b0;
            bypass_bit_valid_out <= 1'b0;
            bypass_bit_data_oe <= 1'b0;
            bypass_bit_valid_oe <= 1'b0;
            tx_bit_strobe <= 1'b0;
            tx_bit_data <= 1'b0;
            tx_bit_valid <= 1'b0;
        end
        else
        begin
            bypass_bit_data_oe <= bypass_enable && rx_mode_active;
            bypass_bit_valid_oe <= bypass_enable && rx_mode_active;
            tx_bit_strobe <= bit_fall && tx_mode_active;
            if (fifo_pop)
            begin
                bypass_bit_data_out <= fifo_data[0];
                bypass_bit_valid_out <= fifo_valid && fifo_data[1];
            end
            if (bit_fall && tx_mode_active)
            begin
                tx_bit_data <= dio_s;
                tx_bit_valid <= bypass_bit_valid_s;
            end
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    miso_released_a: assert property (ss_s |=> !spi_miso_oe)
        else $error("miso driven while deselected");
    cmd_then_data_a: assert property (
        (state == ST_CMD && byte_done && !ss_s && osc_running) |=> state == ST_DATA)
        else $error("command byte did not open data phase");
    read_no_write_a: assert property (
        (byte_done && state == ST_DATA && !is_write)
        |=> $stable(cfg) && $stable(rx_en) && $stable(tx_en) && $stable(wake_en))
        else $error("read command changed a register");
    addr_step_a: assert property (
        (byte_done && state == ST_DATA && !ss_s && osc_running)
        |=> addr == $past(addr) + 6'($past(is_inc)))
        else $error("address step wrong");
    burst_end_a: assert property ((ss_s && state != ST_IDLE) |=> state == ST_IDLE)
        else $error("burst not ended by select");
    wake_clear_a: assert property (
        (rd_stb && rd_addr == ADDR_WAKE_STAT && !wake_set) |=> !wake_stat)
        else $error("wake status not cleared by read");
    status_sticky_a: assert property (|tx_event |=> |tx_stat)
        else $error("transmit event lost");
    ser_b_quiet_a: assert property (
        (single_serializer_mode && rx_stat[7:4] == 4'h0) |=> rx_stat[7:4] == 4'h0)
        else $error("serializer B status set in single mode");
    rx_hidden_a: assert property (
        (tx_mode_active && !rx_mode_active && !wake_hit && !tx_hit && !bypass_enable)
        |=> !irq_oe)
        else $error("receive interrupt not suppressed");
    irq_level_a: assert property (
        (irq_pend && !bypass_enable) |=> irq_oe && irq_out == $past(cfg[CFG_POL_BIT]))
        else $error("interrupt pin level wrong");
    osc_stop_a: assert property (!pd_s |=> !osc_running ##1 !osc_running)
        else $error("oscillator runs in power-down");
    enables_kept_a: assert property (!wr_stb |=> $stable(tx_en) && $stable(rx_en))
        else $error("enable changed without write");
    bypass_rx_a: assert property (
        (fifo_pop && fifo_valid) |=> bypass_bit_data_out == $past(fifo_data[0]))
        else $error("bypass bit not presented");

    burst_write_c: cover property (wr_stb ##[1:200] wr_stb);
    burst_read_c: cover property (rd_stb && state == ST_DATA);
    wake_irq_c: cover property (wake_set ##[1:20] irq_oe);
    bypass_tx_c: cover property (tx_bit_strobe && tx_bit_valid);
endmodule // spi_irq_port

// ===== verif/mcu_model.sv
// Serial master standing in for the application microcontroller.
// Assumes a 40 MHz sys_clk; one serial clock period is eight sys_clk.
`timescale 1ns/1ps
module mcu_model (
    // Clock
    input wire logic sys_clk,
    // Serial pins
    output logic spi_sck,
    output logic spi_mosi,
    output logic spi_ss_n,
    input wire logic spi_miso
);
    // Serial clock stands low between frames
    initial
    begin
        spi_sck = 1'b0;
        spi_mosi = 1'b0;
        spi_ss_n = 1'b1;
    end

    // One frame: command byte, then n data bytes, mode 0
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd[4], input int n,
        output logic [7:0] rd[4]);
        logic [7:0] sh;
        rd = '{default: 8'h00};
        @(posedge sys_clk) #1 spi_ss_n = 1'b0;
        for (int b = 0; b <= n; b++)
        begin
            sh = (b == 0) ? cmd : wd[b-1];
            for (int i = 7; i >= 0; i--)
            begin
                repeat (4) @(posedge sys_clk);
                #1 spi_sck = 1'b0;
                spi_mosi = sh[i];
                repeat (4) @(posedge sys_clk);
                #1 spi_sck = 1'b1;
                if (b > 0)
                    rd[b-1][i] = spi_miso;
            end
        end
        repeat (4) @(posedge sys_clk);
        #1 spi_sck = 1'b0;
        // Select held low across every byte, then released
        repeat (4) @(posedge sys_clk);
        #1 spi_ss_n = 1'b1;
        spi_mosi = ~spi_mosi; // Released line shows no stale level
        repeat (6) @(posedge sys_clk);
        #1;
    endtask
endmodule // mcu_model

// ===== verif/tb_top.sv
// Self-checking bench for the serial host port.
// Assumes mcu_model drives the serial pins; the bench drives the rest.
`timescale 1ns/1ps
module tb_top;
    import spi_port_pkg::*;
    logic sys_clk, sys_rst, spi_sck, spi_mosi, spi_ss_n, spi_miso, spi_miso_oe;
    logic irq_in, irq_out, irq_oe, power_down_n, osc_running;
    logic bypass_bit_data_in, bypass_bit_data_out, bypass_bit_data_oe, bb_d;
    logic bypass_bit_valid_in, bypass_bit_valid_out, bypass_bit_valid_oe, bb_v;
    logic tx_mode_active, rx_mode_active, single_serializer_mode, bypass_enable;
    logic [3:0] tx_event;
    logic [7:0] rx_event;
    logic core_bit_push, core_bit_data, core_bit_valid, core_bit_ready;
    logic tx_bit_strobe, tx_bit_data, tx_bit_valid;
    logic [7:0] wd[4];
    logic [7:0] rd[4];
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    // Pin levels follow whichever side drives
    assign irq_in = irq_oe ? irq_out : 1'b0;
    assign bypass_bit_data_in = bypass_bit_data_oe ? bypass_bit_data_out : bb_d;
    assign bypass_bit_valid_in = bypass_bit_valid_oe ? bypass_bit_valid_out : bb_v;
    spi_irq_port i_dut (.*);
    mcu_model i_mcu (.*);

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Hang guard, well above the expected run
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Inputs always change 1 ns after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        wd[0] = d;
        i_mcu.xfer({2'b10, a}, wd, 1, rd);
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
        i_mcu.xfer({2'b00, a}, wd, 1, rd);
        check(rd[0], exp);
    endtask
    task automatic pulse(input logic [3:0] t, input logic [7:0] r);
        step(1);
        tx_event = t;
        rx_event = r;
        step(1);
        tx_event = 4'h0;
        rx_event = 8'h00;
        step(3);
    endtask
    task automatic wait_irq(input logic lvl);
        for (int k = 0; k < 60 && irq_out !== lvl; k++)
            step(1);
    endtask
    task automatic wait_strobe();
        step(1);
        for (int k = 0; k < 100 && tx_bit_strobe !== 1'b1; k++)
            step(1);
    endtask

    initial
    begin
        sys_rst = 1'b1;
        power_down_n = 1'b0;
        {tx_mode_active, rx_mode_active, single_serializer_mode, bypass_enable} = 4'h0;
        tx_event = 4'h0;
        rx_event = 8'h00;
        {core_bit_push, core_bit_data, core_bit_valid, bb_d, bb_v} = 5'h00;
        wd = '{8'ha5, 8'h3c, 8'h11, 8'h0f};
        step(3);
        sys_rst = 1'b0;
        power_down_n = 1'b1;
        step(40);
        check({7'h0, osc_running}, 8'h00);
        // Serial traffic only once the oscillator runs
        for (int k = 0; k < 100 && osc_running !== 1'b1; k++)
            step(1);
        check({7'h0, osc_running}, 8'h01);
        check({7'h0, spi_miso_oe}, 8'h00);
        rdchk(ADDR_CONFIG, RST_CONFIG);
        rdchk(ADDR_WAKE_STAT, 8'h01);
        rdchk(ADDR_WAKE_STAT, 8'h00);
        rdchk(6'h06, 8'h00);
        pulse(4'h0, 8'h01);
        check({7'h0, irq_oe}, 8'h00);
        rdchk(ADDR_RX_STAT, 8'h01);
        $display("reset and polling test done");
        // Increment burst; the byte landing on the status register is dropped
        i_mcu.xfer({2'b11, ADDR_RX_EN}, wd, 2, rd);
        rdchk(ADDR_RX_EN, 8'ha5);
        rdchk(ADDR_RX_STAT, 8'h00);
        i_mcu.xfer({2'b00, ADDR_RX_EN}, wd, 2, rd);
        check(rd[1], 8'ha5);
        wd = '{8'h11, 8'h0f, 8'h00, 8'h00};
        i_mcu.xfer({2'b10, ADDR_TX_EN}, wd, 2, rd);
        rdchk(ADDR_TX_EN, 8'h0f);
        $display("register test done");
        tx_mode_active = 1'b1;
        pulse(4'h4, 8'h00);
        check({6'h0, irq_oe, irq_out}, 8'h03);
        tx_mode_active = 1'b0;
        rx_mode_active = 1'b1;
        step(3);
        check({7'h0, irq_oe}, 8'h00);
        rdchk(ADDR_TX_EN, 8'h0f);
        rdchk(ADDR_TX_STAT, 8'h04);
        single_serializer_mode = 1'b1;
        pulse(4'h0, 8'hf1);
        rdchk(ADDR_RX_STAT, 8'h01);
        wr(ADDR_CONFIG, 8'h00);
        pulse(4'h0, 8'h01);
        check({6'h0, irq_oe, irq_out}, 8'h02);
        // Pending receive source must vanish from the pin in transmit mode
        {tx_mode_active, rx_mode_active} = 2'b10;
        step(3);
        check({7'h0, irq_oe}, 8'h00);
        {tx_mode_active, rx_mode_active} = 2'b01;
        rdchk(ADDR_RX_STAT, 8'h01);
        step(2);
        check({7'h0, irq_oe}, 8'h00);
        // Wake after a power-down cycle, with its enable set
        wr(ADDR_WAKE_EN, 8'h01);
        check({7'h0, irq_oe}, 8'h00);
        power_down_n = 1'b0;
        step(4);
        check({7'h0, osc_running}, 8'h00);
        power_down_n = 1'b1;
        for (int k = 0; k < 100 && osc_running !== 1'b1; k++)
            step(1);
        step(2);
        check({6'h0, irq_oe, irq_out}, 8'h02);
        rdchk(ADDR_WAKE_STAT, 8'h01);
        step(2);
        check({7'h0, irq_oe}, 8'h00);
        $display("interrupt test done");
        // Fill the buffer while the bit path is off
        for (int i = 0; i < 32; i++)
        begin
            {core_bit_push, core_bit_valid, core_bit_data} = {2'b11, i[1]};
            step(1);
        end
        core_bit_push = 1'b0;
        step(1);
        check({7'h0, core_bit_ready}, 8'h00);
        bypass_enable = 1'b1;
        // One extra bit clock shows the empty buffer
        for (int i = 0; i < 33; i++)
        begin
            wait_irq(1'b1);
            wait_irq(1'b0);
            wait_irq(1'b1);
            check({6'h0, bypass_bit_valid_out, bypass_bit_data_out & (i < 32)},
                {6'h0, i < 32, i[1]});
        end
        check({5'h0, irq_oe, bypass_bit_data_oe, bypass_bit_valid_oe}, 8'h07);
        rx_mode_active = 1'b0;
        tx_mode_active = 1'b1;
        {bb_d, bb_v} = 2'b11;
        wait_strobe();
        wait_strobe();
        check({6'h0, tx_bit_valid, tx_bit_data}, 8'h03);
        bb_d = 1'b0;
        wait_strobe();
        wait_strobe();
        check({4'h0, bypass_bit_data_oe, bypass_bit_valid_oe, tx_bit_valid, tx_bit_data},
            8'h02);
        $display("bypass test done");
        summarize();
    end
endmodule // tb_top
